// ==== core/rlc_defines.svh ====
// Constants for the line-direction and clock-select block.
// Assumes inclusion by bare name from every file that needs them.
//
// Summary of operation
// - Only one node drives the shared bus.
// - Auto mode: hardware alone switches the driver.
// - RTS mode: driver enable follows UART RTS.
// - Echo: receiver stays on while transmitting.
// - No echo: receiver off while driver active.
// - Reference clock prescaler divides by four or one.
// - Divide-by-four gives standard rates up to 115.2K.
// - Divide-by-one allows up to 460.8K bps.
// - Divide-by-one line rate is four times programmed.
`ifndef RLC_DEFINES_SVH
`define RLC_DEFINES_SVH

`define RLC_ADDR_W        4
`define RLC_DATA_W        32
`define RLC_OFS_SWITCH    4'h0
`define RLC_OFS_STATUS    4'h4

`define RLC_CFG_W         5
`define RLC_CFG_AUTO      0
`define RLC_CFG_RTS       1
`define RLC_CFG_NOECHO    2
`define RLC_CFG_DIV1      3
`define RLC_CFG_DIV4      4
`define RLC_CFG_RST       5'h11

`define RLC_STAT_W        4
`define RLC_STAT_DRV      0
`define RLC_STAT_RCV      1
`define RLC_STAT_BADCLK   2
`define RLC_STAT_BUSY     3

`define RLC_PRE_W         2
`define RLC_PRE_ZERO      2'h0
`define RLC_PRE_ONE       2'h1
`define RLC_PRE_LAST      2'h3

`define RLC_RATE_DIV4_BPS 115200
`define RLC_RATE_DIV1_BPS 460800

`endif

// ==== core/rlc_pkg.sv ====
// Types shared by the line-direction and clock-select block.
// Assumes the constants header is compiled alongside.
package rlc_pkg;

  typedef enum logic [1:0] {
    st_idle  = 2'h1,
    st_drive = 2'h2
  } rlc_drv_state_e;

endpackage

// ==== core/rlc_prescaler.sv ====
// UART reference clock prescaler, producing a one-cycle reference tick.
// Assumes the select inputs come from flip-flops in the same clock domain.
`timescale 1ns/1ps
`include "rlc_defines.svh"

module rlc_prescaler (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_by_one,
  input  wire logic i_by_four,
  output logic      o_ref_tick,
  output logic      o_clk_invalid
);

  logic [`RLC_PRE_W-1:0] cnt_q;
  logic [`RLC_PRE_W-1:0] cnt_d;
  logic                  tick_q;
  logic                  tick_d;
  logic                  bad_q;
  logic                  bad_d;

  // Both selects on is illegal, so the tick is held off rather than glitching.
  always_comb begin
    bad_d  = i_by_one & i_by_four;
    cnt_d  = `RLC_PRE_ZERO;
    tick_d = 1'b0;
    if (!bad_d && i_by_four) begin
      cnt_d  = cnt_q + `RLC_PRE_ONE;
      tick_d = (cnt_q == `RLC_PRE_LAST);
    end else if (!bad_d && i_by_one) begin
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_q  <= `RLC_PRE_ZERO;
      tick_q <= 1'b0;
      bad_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
      bad_q  <= bad_d;
    end
  end

  assign o_ref_tick    = tick_q;
  assign o_clk_invalid = bad_q;

endmodule

// ==== core/rlc_line_ctrl.sv ====
// Line-direction control and UART clock select for one serial channel.
// Assumes the UART reports character starts and transmitter idle in this clock domain.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "rlc_defines.svh"

module rlc_line_ctrl (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  input  wire logic [`RLC_ADDR_W-1:0] i_addr,
  input  wire logic [`RLC_DATA_W-1:0] i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [`RLC_DATA_W-1:0] o_rdata,
  input  wire logic                   i_uart_tx_start,
  input  wire logic                   i_uart_tx_idle,
  input  wire logic                   i_uart_rts,
  output logic                        o_line_drv_en,
  output logic                        o_line_rcv_en,
  output logic                        o_uart_ref_tick,
  output logic                        o_clk_invalid
);

  // Switch bank register.
  logic [`RLC_CFG_W-1:0]  cfg_q;
  logic [`RLC_CFG_W-1:0]  cfg_d;
  logic                   cfg_wr;
  logic                   auto_sel;
  logic                   rts_sel;
  logic                   noecho_sel;

  assign cfg_wr     = i_wr && (i_addr == `RLC_OFS_SWITCH);
  assign auto_sel   = cfg_q[`RLC_CFG_AUTO];
  assign rts_sel    = cfg_q[`RLC_CFG_RTS];
  assign noecho_sel = cfg_q[`RLC_CFG_NOECHO];

  always_comb begin
    cfg_d = cfg_q;
    if (cfg_wr) begin
      cfg_d = i_wdata[`RLC_CFG_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cfg_q <= `RLC_CFG_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Driver and receiver enables.
  rlc_pkg::rlc_drv_state_e state_q;
  rlc_pkg::rlc_drv_state_e state_d;
  logic                    drv_q;
  logic                    drv_d;
  logic                    rcv_q;
  logic                    rcv_d;

  always_comb begin
    state_d = state_q;
    if (!auto_sel) begin
      state_d = rlc_pkg::st_idle;
    end else begin
      case (state_q)
        rlc_pkg::st_idle: begin
          if (i_uart_tx_start) begin
            state_d = rlc_pkg::st_drive;
          end
        end
        rlc_pkg::st_drive: begin
          // The UART idle flag covers both the shift register and its queue.
          if (i_uart_tx_idle && !i_uart_tx_start) begin
            state_d = rlc_pkg::st_idle;
          end
        end
        default: begin
          state_d = rlc_pkg::st_idle;
        end
      endcase
    end
    // Auto wins over RTS; with neither the port is point-to-point and drives always.
    if (auto_sel) begin
      drv_d = (state_d == rlc_pkg::st_drive);
    end else if (rts_sel) begin
      drv_d = i_uart_rts;
    end else begin
      drv_d = 1'b1;
    end
    // Receiver is gated from the next driver value so both pins switch together.
    rcv_d = !(noecho_sel && drv_d);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q <= rlc_pkg::st_idle;
      drv_q   <= 1'b0;
      rcv_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      drv_q   <= drv_d;
      rcv_q   <= rcv_d;
    end
  end

  assign o_line_drv_en = drv_q;
  assign o_line_rcv_en = rcv_q;

  // Reference clock prescaler.
  rlc_prescaler u_prescaler (
    .i_core_clk    (i_core_clk),
    .i_rst_n       (i_rst_n),
    .i_by_one      (cfg_q[`RLC_CFG_DIV1]),
    .i_by_four     (cfg_q[`RLC_CFG_DIV4]),
    .o_ref_tick    (o_uart_ref_tick),
    .o_clk_invalid (o_clk_invalid)
  );

  // Register read port.
  logic [`RLC_DATA_W-1:0] rdata_q;
  logic [`RLC_DATA_W-1:0] rdata_d;
  logic [`RLC_STAT_W-1:0] status;

  always_comb begin
    status                  = '0;
    status[`RLC_STAT_DRV]   = drv_q;
    status[`RLC_STAT_RCV]   = rcv_q;
    status[`RLC_STAT_BADCLK] = o_clk_invalid;
    status[`RLC_STAT_BUSY]  = (state_q == rlc_pkg::st_drive);
    rdata_d                 = '0;
    if (i_rd) begin
      case (i_addr)
        `RLC_OFS_SWITCH: begin
          rdata_d[`RLC_CFG_W-1:0] = cfg_q;
        end
        `RLC_OFS_STATUS: begin
          rdata_d[`RLC_STAT_W-1:0] = status;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // Checks.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic div4_only;
  logic div1_only;
  assign div4_only = cfg_q[`RLC_CFG_DIV4] && !cfg_q[`RLC_CFG_DIV1];
  assign div1_only = cfg_q[`RLC_CFG_DIV1] && !cfg_q[`RLC_CFG_DIV4];

  chk_rts_follow: assert property (
    (rts_sel && !auto_sel && !cfg_wr) |=> (o_line_drv_en == $past(i_uart_rts)))
    else $error("Driver enable does not follow RTS.");

  chk_auto_start: assert property (
    (auto_sel && !cfg_wr && i_uart_tx_start) |=> o_line_drv_en)
    else $error("Driver not enabled at character start.");

  chk_auto_hold: assert property (
    (auto_sel && !cfg_wr && o_line_drv_en && !i_uart_tx_idle) |=> o_line_drv_en)
    else $error("Driver released before last stop bit.");

  chk_auto_release: assert property (
    (auto_sel && !cfg_wr && o_line_drv_en && i_uart_tx_idle && !i_uart_tx_start) |=> !o_line_drv_en)
    else $error("Driver not released after transmitter idle.");

  chk_bus_quiet: assert property (
    (auto_sel && !cfg_wr && !o_line_drv_en && !i_uart_tx_start) |=> !o_line_drv_en)
    else $error("Driver enabled with nothing to send.");

  chk_echo_kept: assert property (
    (!noecho_sel && $stable(noecho_sel)) |-> o_line_rcv_en)
    else $error("Receiver disabled while echo is permitted.");

  chk_echo_cut: assert property (
    (noecho_sel && $stable(noecho_sel)) |-> (o_line_rcv_en == !o_line_drv_en))
    else $error("Receiver not gated by driver in no-echo mode.");

  chk_rcv_echo_on: assert property (
    (!noecho_sel && !cfg_wr) |=> o_line_rcv_en)
    else $error("Receiver cut while echo is selected.");

  // A stray tick with no divide selected would clock the UART from nothing.
  chk_no_div_quiet: assert property (
    (!cfg_q[`RLC_CFG_DIV1] && !cfg_q[`RLC_CFG_DIV4] && !cfg_wr) |=> !o_uart_ref_tick)
    else $error("Reference tick with no divide selected.");

  chk_div4_rate: assert property (
    disable iff (!i_rst_n || cfg_wr)
    (div4_only && o_uart_ref_tick) |=> (!o_uart_ref_tick [*3]) ##1 o_uart_ref_tick)
    else $error("Divide-by-four tick spacing is not four cycles.");

  chk_div1_rate: assert property (
    (div1_only && !cfg_wr) |=> o_uart_ref_tick)
    else $error("Divide-by-one tick missing.");

  chk_bad_clock: assert property (
    (cfg_q[`RLC_CFG_DIV1] && cfg_q[`RLC_CFG_DIV4] && !cfg_wr) |=> (o_clk_invalid && !o_uart_ref_tick))
    else $error("Invalid clock selection not suppressed.");

  cov_auto_frame: cover property (
    auto_sel && i_uart_tx_start ##1 o_line_drv_en ##[1:100] !o_line_drv_en);

  cov_rts_drive: cover property (rts_sel && !auto_sel && o_line_drv_en);

  cov_noecho_tx: cover property (noecho_sel && o_line_drv_en && !o_line_rcv_en);

  cov_div4_tick: cover property (div4_only && o_uart_ref_tick ##4 o_uart_ref_tick);

endmodule

// ==== tb/rlc_uart_node.sv ====
// Model of the UART transmitter and of one remote node on the shared bus.
// Assumes the bench pulses i_send for one cycle to queue one character.
`timescale 1ns/1ps

module rlc_uart_node #(
  parameter int CHAR_CYC = 20
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_send,
  output logic      o_tx_start,
  output logic      o_tx_idle,
  output logic      o_remote_drv
);
  int cnt;
  int quiet;

  // A send during a character restarts the count, so the queue drains later.
  always @(posedge i_core_clk) begin
    o_tx_start <= 1'b0;
    if (!i_rst_n) begin
      cnt <= 0;
    end else if (i_send) begin
      o_tx_start <= 1'b1;
      cnt        <= CHAR_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  // The remote node answers only after two quiet cycles of line turnaround.
  always @(posedge i_core_clk) begin
    if (!i_rst_n || i_send || cnt > 0) begin
      quiet <= 0;
    end else if (quiet < 2) begin
      quiet <= quiet + 1;
    end
  end

  assign o_tx_idle    = (cnt == 0);
  assign o_remote_drv = (quiet == 2);
endmodule

// ==== tb/rlc_line_ctrl_tb.sv ====
// Self-checking bench for the line-direction and clock-select block.
// Assumes the constants header and the design files are compiled first.
`timescale 1ns/1ps
`include "rlc_defines.svh"

`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end

module rlc_line_ctrl_tb;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n    = 1'b0;
  logic [3:0]  i_addr     = 4'h0;
  logic [31:0] i_wdata    = 32'h0;
  logic        i_wr       = 1'b0;
  logic        i_rd       = 1'b0;
  logic        i_uart_rts = 1'b0;
  logic        send       = 1'b0;
  logic [31:0] o_rdata;
  logic        tx_start, tx_idle, drv, rcv, tick, bad, remote;
  int          fail_count, compares, cyc;

  always #20 i_core_clk = ~i_core_clk;

  rlc_line_ctrl DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_uart_tx_start(tx_start), .i_uart_tx_idle(tx_idle),
    .i_uart_rts(i_uart_rts), .o_line_drv_en(drv), .o_line_rcv_en(rcv), .o_uart_ref_tick(tick),
    .o_clk_invalid(bad));

  rlc_uart_node #(.CHAR_CYC(20)) u_node (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_send(send),
    .o_tx_start(tx_start), .o_tx_idle(tx_idle), .o_remote_drv(remote));

  task automatic cyc_n(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_core_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, e)
  endtask

  task automatic send_char;
    @(posedge i_core_clk);
    send <= 1'b1;
    @(posedge i_core_clk);
    send <= 1'b0;
    #1;
  endtask

  task automatic wait_drv(input logic v);
    int n;
    n = 0;
    while (drv !== v && n < 60) begin
      cyc_n(1);
      n++;
    end
    `CHK(drv, v)
  endtask

  // Registers: reset value, unmapped read, read-only status.
  task automatic t_regs;
    rd(`RLC_OFS_SWITCH, 32'h0000_0011);
    rd(4'h8, 32'h0000_0000);
    wr(`RLC_OFS_STATUS, 32'h0000_000F);
    rd(`RLC_OFS_STATUS, 32'h0000_0002);
    $display("t_regs done");
  endtask

  // Auto mode with no echo: RTS stays low yet the driver follows traffic.
  task automatic t_auto;
    wr(`RLC_OFS_SWITCH, 32'h0000_0015);
    send_char();
    wait_drv(1'b1);
    `CHK(rcv, 1'b0)
    `CHK(drv & remote, 1'b0)
    rd(`RLC_OFS_STATUS, 32'h0000_0009);
    rd(`RLC_OFS_SWITCH, 32'h0000_0015);
    cyc_n(10);
    send_char();
    cyc_n(18);
    `CHK(drv, 1'b1)
    wait_drv(1'b0);
    `CHK(tx_idle, 1'b1)
    `CHK(rcv, 1'b1)
    cyc_n(2);
    `CHK(remote, 1'b1)
    `CHK(drv & remote, 1'b0)
    $display("t_auto done");
  endtask

  // RTS mode with echo: one cycle from RTS to the driver.
  task automatic t_rts;
    wr(`RLC_OFS_SWITCH, 32'h0000_0012);
    @(posedge i_core_clk);
    i_uart_rts <= 1'b1;
    cyc_n(1);
    `CHK(drv, 1'b1)
    `CHK(rcv, 1'b1)
    @(posedge i_core_clk);
    i_uart_rts <= 1'b0;
    cyc_n(1);
    `CHK(drv, 1'b0)
    $display("t_rts done");
  endtask

  // Prescaler: ticks in 40 cycles for each select setting.
  task automatic t_clk(input logic [31:0] cfg, input int exp_n, input logic exp_bad);
    int n;
    n = 0;
    wr(`RLC_OFS_SWITCH, cfg);
    cyc_n(3);
    repeat (40) begin
      n += (tick === 1'b1);
      cyc_n(1);
    end
    `CHK(n, exp_n)
    `CHK(bad, exp_bad)
    $display("t_clk %0h done", cfg);
  endtask

  task automatic complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // The ceiling is well above the few hundred cycles the tests need.
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_auto();
    t_rts();
    t_clk(32'h0000_0011, 10, 1'b0);
    t_clk(32'h0000_0009, 40, 1'b0);
    t_clk(32'h0000_0019, 0, 1'b1);
    t_clk(32'h0000_0001, 0, 1'b0);
    complete_run();
  end
endmodule
